//--- inc/tcc_params.svh
`ifndef TCC_PARAMS_SVH
`define TCC_PARAMS_SVH

// bus geometry
`define TCC_ADDR_W 8
`define TCC_DATA_W 32

// register byte offsets
`define TCC_OFS_CTRL 8'h00
`define TCC_OFS_COUNT 8'h04
`define TCC_OFS_COMPARE 8'h08
`define TCC_OFS_FLAGS 8'h0C
`define TCC_OFS_IRQ_EN 8'h10

// one-hot register select positions
`define TCC_SEL_CTRL 0
`define TCC_SEL_COUNT 1
`define TCC_SEL_COMPARE 2
`define TCC_SEL_FLAGS 3
`define TCC_SEL_IRQ_EN 4
`define TCC_NUM_REGS 5

// flag bit positions in the flag and enable registers
`define TCC_FLG_OVERFLOW 0
`define TCC_FLG_CMP_A 1
`define TCC_FLG_CMP_B 2
`define TCC_FLG_CAPTURE 3
`define TCC_NUM_FLAGS 4

// reset values
`define TCC_CTRL_RST 8'h00
`define TCC_COUNT_RST 16'h0000
`define TCC_COMPARE_RST 8'h00
`define TCC_FLAGS_RST 4'h0

// counter limits
`define TCC_MAX8 8'hFF
`define TCC_MAX16 16'hFFFF
`define TCC_BOTTOM8 8'h00

// prescaler: clock source codes and divide masks
`define TCC_CS_STOP 3'h0
`define TCC_CS_DIV1 3'h1
`define TCC_CS_DIV8 3'h2
`define TCC_CS_DIV64 3'h3
`define TCC_CS_DIV256 3'h4
`define TCC_DIV8_MASK 8'h07
`define TCC_DIV64_MASK 8'h3F
`define TCC_DIV256_MASK 8'hFF

// noise canceler sample depth
`define TCC_NC_DEPTH 4

// axi responses
`define TCC_RESP_OKAY 2'h0
`define TCC_RESP_SLVERR 2'h2

`endif

//--- inc/tcc_pkg.sv
package tcc_pkg;

  // control register layout, msb first
  typedef struct packed {
    logic width_select;
    logic capture_mode_enable;
    logic noise_cancel;
    logic capture_edge_select;
    logic clear_on_match_select;
    logic [2:0] clock_source_select;
  } tcc_ctrl_t;

  // flag and interrupt-enable layout
  typedef struct packed {
    logic capture_flag;
    logic compare_flag_b;
    logic compare_flag_a;
    logic overflow_flag;
  } tcc_flags_t;

  // operating modes, one-hot
  typedef enum logic [4:0] {
    TCC_NORMAL8 = 5'b00001,
    TCC_CLEAR_ON_MATCH8 = 5'b00010,
    TCC_NORMAL16 = 5'b00100,
    TCC_CAPTURE8 = 5'b01000,
    TCC_CAPTURE16 = 5'b10000
  } tcc_mode_t;

endpackage

//--- rtl/tcc_prescaler.sv
`timescale 1ns/1ps
`include "tcc_params.svh"

module tcc_prescaler (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [2:0] clock_source_select,
  output logic timer_tick
);

  logic [7:0] div_reg;

  // free-running divider, shared by every divided rate
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end

  // one-cycle enable at the selected rate; unknown codes stop the timer
  always_comb begin
    case (clock_source_select)
      `TCC_CS_DIV1: timer_tick = 1'b1;
      `TCC_CS_DIV8: timer_tick = (div_reg & `TCC_DIV8_MASK) == `TCC_DIV8_MASK;
      `TCC_CS_DIV64: timer_tick = (div_reg & `TCC_DIV64_MASK) == `TCC_DIV64_MASK;
      `TCC_CS_DIV256: timer_tick = div_reg == `TCC_DIV256_MASK;
      default: timer_tick = 1'b0;
    endcase
  end

endmodule

//--- rtl/tcc_capture.sv
`timescale 1ns/1ps
`include "tcc_params.svh"

module tcc_capture (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic capture_pin,
  input wire logic noise_cancel,
  input wire logic capture_edge_select,
  input wire logic capture_active,
  output logic capture_event
);

  logic pin_reg;
  logic [`TCC_NC_DEPTH-1:0] hist_reg;
  logic filt_reg;
  logic prev_reg;
  logic level;

  // sample the pin and keep a short history for the filter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_reg <= 1'b0;
      hist_reg <= '0;
    end else begin
      pin_reg <= capture_pin;
      hist_reg <= {hist_reg[`TCC_NC_DEPTH-2:0], pin_reg};
    end
  end

  // filter output moves only when all samples agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      filt_reg <= 1'b0;
    end else if (&hist_reg) begin
      filt_reg <= 1'b1;
    end else if (~|hist_reg) begin
      filt_reg <= 1'b0;
    end
  end

  assign level = noise_cancel ? filt_reg : pin_reg;

  // edge detector follows whichever level is selected
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= level;
    end
  end

  // rising when the select bit is one, falling when zero
  assign capture_event = capture_active &
    (capture_edge_select ? (level & ~prev_reg) : (~level & prev_reg));

endmodule

//--- rtl/tcc_top.sv
// Added by the designer: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`include "tcc_params.svh"

module tcc_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`TCC_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [`TCC_DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [`TCC_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [`TCC_DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic capture_pin,
  input wire tcc_pkg::tcc_flags_t irq_ack,
  output tcc_pkg::tcc_flags_t irq_req
);

  // address decode to a one-hot select; shared by reads and writes
  function automatic logic [`TCC_NUM_REGS-1:0] decode(input logic [`TCC_ADDR_W-1:0] a);
    logic [`TCC_NUM_REGS-1:0] sel;
    sel = '0;
    case (a)
      `TCC_OFS_CTRL: sel[`TCC_SEL_CTRL] = 1'b1;
      `TCC_OFS_COUNT: sel[`TCC_SEL_COUNT] = 1'b1;
      `TCC_OFS_COMPARE: sel[`TCC_SEL_COMPARE] = 1'b1;
      `TCC_OFS_FLAGS: sel[`TCC_SEL_FLAGS] = 1'b1;
      `TCC_OFS_IRQ_EN: sel[`TCC_SEL_IRQ_EN] = 1'b1;
      default: sel = '0;
    endcase
    return sel;
  endfunction

  // byte-lane merge of a 16-bit field
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
                                           input logic [1:0] strb);
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = nw[7:0];
    end
    if (strb[1]) begin
      res[15:8] = nw[15:8];
    end
    return res;
  endfunction

  // mode from capture-enable, width and clear-on-match bits
  function automatic tcc_pkg::tcc_mode_t mode_of(input tcc_pkg::tcc_ctrl_t c);
    tcc_pkg::tcc_mode_t m;
    case ({c.capture_mode_enable, c.width_select})
      2'b00: m = c.clear_on_match_select ? tcc_pkg::TCC_CLEAR_ON_MATCH8 : tcc_pkg::TCC_NORMAL8;
      2'b01: m = tcc_pkg::TCC_NORMAL16;
      2'b10: m = tcc_pkg::TCC_CAPTURE8;
      2'b11: m = tcc_pkg::TCC_CAPTURE16;
      default: m = tcc_pkg::TCC_NORMAL8;
    endcase
    return m;
  endfunction

  tcc_pkg::tcc_ctrl_t ctrl_reg;
  tcc_pkg::tcc_flags_t flags_reg;
  tcc_pkg::tcc_flags_t irq_en_reg;
  tcc_pkg::tcc_flags_t flag_set;
  tcc_pkg::tcc_flags_t flag_clr;
  tcc_pkg::tcc_mode_t mode;
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic [7:0] compare_a_reg;
  logic [7:0] compare_b_reg;
  logic block_reg;
  logic timer_tick;
  logic capture_event;
  logic capture_active;
  logic is_wide;
  logic at_max;
  logic match_a;
  logic match_b;
  logic clear_hit;

  logic aw_have_reg;
  logic w_have_reg;
  logic [`TCC_ADDR_W-1:0] aw_addr_reg;
  logic [`TCC_DATA_W-1:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [`TCC_DATA_W-1:0] rdata_reg;
  logic wr_fire;
  logic [`TCC_NUM_REGS-1:0] wr_sel;
  logic [`TCC_NUM_REGS-1:0] rd_sel;
  logic count_wr;
  logic compare_wr;

  // prescaled tick is a clock enable, never a clock
  tcc_prescaler u_prescaler (
    .aclk(aclk),
    .aresetn(aresetn),
    .clock_source_select(ctrl_reg.clock_source_select), // zero gives no tick
    .timer_tick(timer_tick)
  );

  tcc_capture u_capture (
    .aclk(aclk),
    .aresetn(aresetn),
    .capture_pin(capture_pin),
    .noise_cancel(ctrl_reg.noise_cancel),
    .capture_edge_select(ctrl_reg.capture_edge_select),
    .capture_active(capture_active),
    .capture_event(capture_event)
  );

  // ---- axi4-lite write channel ----
  // one write in flight; new address or data waits until the response leaves
  assign awready = ~aw_have_reg & ~bvalid_reg;
  assign wready = ~w_have_reg & ~bvalid_reg;
  assign wr_fire = aw_have_reg & w_have_reg & ~bvalid_reg;
  assign wr_sel = wr_fire ? decode(aw_addr_reg) : '0;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;

  // address and data may arrive in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (awvalid & awready) begin
      aw_have_reg <= 1'b1;
      aw_addr_reg <= awaddr;
    end else if (wr_fire) begin
      aw_have_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= 4'h0;
    end else if (wvalid & wready) begin
      w_have_reg <= 1'b1;
      w_data_reg <= wdata;
      w_strb_reg <= wstrb;
    end else if (wr_fire) begin
      w_have_reg <= 1'b0;
    end
  end

  // response one cycle after both halves are held; unmapped gives slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `TCC_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= (|decode(aw_addr_reg)) ? `TCC_RESP_OKAY : `TCC_RESP_SLVERR;
    end else if (bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // ---- axi4-lite read channel ----
  assign arready = ~rvalid_reg;
  assign rd_sel = decode(araddr);
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;

  // read data latched on address handshake, unused bits zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rresp_reg <= `TCC_RESP_OKAY;
      rdata_reg <= '0;
    end else if (arvalid & arready) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= (|rd_sel) ? `TCC_RESP_OKAY : `TCC_RESP_SLVERR;
      case (1'b1)
        rd_sel[`TCC_SEL_CTRL]: rdata_reg <= {24'h00_0000, ctrl_reg};
        rd_sel[`TCC_SEL_COUNT]: rdata_reg <= {16'h0000, count_reg};
        rd_sel[`TCC_SEL_COMPARE]: rdata_reg <= {16'h0000, compare_b_reg, compare_a_reg};
        rd_sel[`TCC_SEL_FLAGS]: rdata_reg <= {28'h000_0000, flags_reg};
        rd_sel[`TCC_SEL_IRQ_EN]: rdata_reg <= {28'h000_0000, irq_en_reg};
        default: rdata_reg <= '0;
      endcase
    end else if (rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ---- control and enable registers ----
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= `TCC_CTRL_RST;
    end else if (wr_sel[`TCC_SEL_CTRL] & w_strb_reg[0]) begin
      ctrl_reg <= w_data_reg[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_en_reg <= `TCC_FLAGS_RST;
    end else if (wr_sel[`TCC_SEL_IRQ_EN] & w_strb_reg[0]) begin
      irq_en_reg <= w_data_reg[`TCC_NUM_FLAGS-1:0];
    end
  end

  // ---- mode and comparators ----
  assign mode = mode_of(ctrl_reg);
  assign is_wide = (mode == tcc_pkg::TCC_NORMAL16) | (mode == tcc_pkg::TCC_CAPTURE16);
  assign capture_active = (mode == tcc_pkg::TCC_CAPTURE8) | (mode == tcc_pkg::TCC_CAPTURE16);

  // compare a is the capture register in capture modes, so it has no match there
  always_comb begin
    case (mode)
      tcc_pkg::TCC_NORMAL8: match_a = count_reg[7:0] == compare_a_reg;
      tcc_pkg::TCC_CLEAR_ON_MATCH8: match_a = count_reg[7:0] == compare_a_reg;
      tcc_pkg::TCC_NORMAL16: match_a = count_reg == {compare_b_reg, compare_a_reg};
      default: match_a = 1'b0;
    endcase
  end

  // unit b exists only while the width is 8 bits
  assign match_b = ~is_wide & (count_reg[7:0] == compare_b_reg);

  // top is the fixed maximum in every mode, clear-on-match included
  assign at_max = is_wide ? (count_reg == `TCC_MAX16) : (count_reg[7:0] == `TCC_MAX8);

  // exact equality only: a compare below the count waits for the wrap
  assign clear_hit = (mode == tcc_pkg::TCC_CLEAR_ON_MATCH8) & match_a;

  // ---- counter ----
  assign count_wr = wr_sel[`TCC_SEL_COUNT] & (|w_strb_reg[1:0]); // any time, any mode

  always_comb begin
    count_next = count_reg;
    if (count_wr) begin
      count_next = merge16(count_reg, w_data_reg[15:0], w_strb_reg[1:0]);
    end else if (timer_tick) begin
      if (clear_hit) begin
        count_next = {count_reg[15:8], `TCC_BOTTOM8};
      end else if (is_wide) begin
        count_next = count_reg + 16'h0001; // wraps to zero
      end else begin
        count_next = {count_reg[15:8], count_reg[7:0] + 8'h01};
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_reg <= `TCC_COUNT_RST;
    end else begin
      count_reg <= count_next; // stands still with no tick
    end
  end

  // a counter write masks matches up to and including the next tick,
  // even while stopped, so preloading the compare value stays silent
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      block_reg <= 1'b0;
    end else if (count_wr) begin
      block_reg <= 1'b1;
    end else if (timer_tick) begin
      block_reg <= 1'b0;
    end
  end

  // ---- compare / capture register ----
  // writes land at once; a capture in the same cycle wins over software
  assign compare_wr = wr_sel[`TCC_SEL_COMPARE] & (|w_strb_reg[1:0]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      compare_a_reg <= `TCC_COMPARE_RST;
      compare_b_reg <= `TCC_COMPARE_RST;
    end else if (capture_event) begin
      compare_a_reg <= count_reg[7:0]; // overwrite unread value
      if (mode == tcc_pkg::TCC_CAPTURE16) begin
        compare_b_reg <= count_reg[15:8];
      end
    end else if (compare_wr) begin
      {compare_b_reg, compare_a_reg} <= merge16({compare_b_reg, compare_a_reg},
                                                w_data_reg[15:0], w_strb_reg[1:0]);
    end
  end

  // ---- flag sources ----
  always_comb begin
    flag_set = '0;
    // overflow on every rollover from max, also in clear-on-match
    flag_set.overflow_flag = timer_tick & ~count_wr & at_max;
    // flag follows the tick at which the match was seen
    flag_set.compare_flag_a = timer_tick & match_a & ~block_reg & ~count_wr;
    flag_set.compare_flag_b = timer_tick & match_b & ~block_reg & ~count_wr;
    flag_set.capture_flag = capture_event; // same cycle as the copy
  end

  // software clears by ones only; service acknowledge also clears
  always_comb begin
    flag_clr = irq_ack;
    if (wr_sel[`TCC_SEL_FLAGS] & w_strb_reg[0]) begin
      flag_clr = flag_clr | w_data_reg[`TCC_NUM_FLAGS-1:0]; // zeros keep flags
    end
  end

  // set beats clear so an event meeting a clear is kept
  genvar gi;
  generate
    for (gi = 0; gi < `TCC_NUM_FLAGS; gi++) begin : g_flag
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          flags_reg[gi] <= 1'b0;
        end else if (flag_set[gi]) begin
          flags_reg[gi] <= 1'b1; // hardware only sets
        end else if (flag_clr[gi]) begin
          flags_reg[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // request per flag, gated by its enable
  assign irq_req = flags_reg & irq_en_reg;

endmodule

//--- dv/tcc_properties.sv
`timescale 1ns/1ps
`include "tcc_params.svh"

module tcc_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [`TCC_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [`TCC_DATA_W-1:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire tcc_pkg::tcc_flags_t irq_ack,
  input wire tcc_pkg::tcc_flags_t irq_req
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // both write halves taken at one edge
  sequence s_both_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  // register update edge first, response after it
  sequence s_resp_next;
    !bvalid ##1 bvalid;
  endsequence
  // read address names one of the five registers
  logic mapped;
  assign mapped = araddr inside {`TCC_OFS_CTRL, `TCC_OFS_COUNT, `TCC_OFS_COMPARE,
    `TCC_OFS_FLAGS, `TCC_OFS_IRQ_EN};

  a_write_latency: assert property (s_both_taken |=> s_resp_next)
    else $error("write response not on the second edge");
  a_resp_once: assert property (bvalid && bready |=> !bvalid)
    else $error("write response repeated");
  a_aw_blocked: assert property (bvalid |-> !awready && !wready)
    else $error("write channels open during a response");
  a_read_latency: assert property (arvalid && arready |=> rvalid)
    else $error("read data late");
  a_ar_blocked: assert property (rvalid |-> !arready)
    else $error("read address open during read data");
  a_mapped_okay: assert property (arvalid && arready && mapped |=> rresp == `TCC_RESP_OKAY)
    else $error("mapped read refused");
  a_unmapped_err: assert property (arvalid && arready && !mapped
    |=> rresp == `TCC_RESP_SLVERR && rdata == 32'h0)
    else $error("unmapped read not refused");
  // a request may only fall after service or a register write
  a_req_drop_cause: assert property (|($past(irq_req) & ~irq_req & ~$past(irq_ack))
    |-> $past(awvalid && awready, 2) || $past(wvalid && wready, 2))
    else $error("interrupt request dropped without cause");
  a_reset_quiet: assert property (!$past(aresetn) |-> irq_req == 4'h0 && !bvalid && !rvalid)
    else $error("outputs busy right after reset");
endmodule

bind tcc_top tcc_properties u_props (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
  .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
  .rresp(rresp), .rvalid(rvalid), .irq_ack(irq_ack), .irq_req(irq_req)
);

//--- dv/testbench.sv
`timescale 1ns/1ps
`include "tcc_params.svh"

module testbench;
  typedef struct packed {
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] e;
    logic [1:0] r;
  } tcc_row_t;
  logic aclk, aresetn, awvalid, wvalid, bvalid, bready, arvalid, rvalid, rready;
  logic awready, wready, arready, capture_pin;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rdv;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp;
  tcc_pkg::tcc_flags_t irq_ack, irq_req, seen;
  int miscompares, checked, i;
  tcc_row_t rows [7];

  tcc_top uut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .capture_pin(capture_pin), .irq_ack(irq_ack), .irq_req(irq_req)
  );

  // 20 mhz system clock
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch at %0t: got %h, wanted %h", $time, g, e);
    end
  endtask

  // readies sampled mid-cycle, so the edge's own update never races the look;
  // bready stays high, so a response is taken on the edge after it shows
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok, b_ok;
    b_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (int k = 0; k < 50 && !b_ok; k++) begin
      @(negedge aclk);
      aw_ok = awvalid & awready;
      w_ok = wvalid & wready;
      b_ok = bvalid;
      rsp = bresp;
      @(posedge aclk);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
    end
    if (!b_ok) begin
      miscompares++;
      $display("mismatch at %0t: write response missing", $time);
    end
  endtask

  task automatic rd(input logic [7:0] a);
    logic ar_ok, r_ok;
    r_ok = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    for (int k = 0; k < 50 && !r_ok; k++) begin
      @(negedge aclk);
      ar_ok = arvalid & arready;
      r_ok = rvalid;
      rdv = rdata;
      rsp = rresp;
      @(posedge aclk);
      if (ar_ok) arvalid <= 1'b0;
    end
    if (!r_ok) begin
      miscompares++;
      $display("mismatch at %0t: read data missing", $time);
    end
  endtask

  // bounded wait for any masked request, ends on a rising edge
  task automatic wait_req(input logic [3:0] m);
    logic hit;
    hit = 1'b0;
    for (int k = 0; k < 600 && !hit; k++) begin
      @(negedge aclk);
      seen = irq_req;
      hit = (seen & m) != 4'h0;
    end
    @(posedge aclk);
    if (!hit) begin
      miscompares++;
      $display("mismatch at %0t: request never raised", $time);
    end
  endtask

  // load while stopped so no tick races the setup
  task automatic setup(input logic [7:0] c, input logic [15:0] n, input logic [15:0] p);
    wr(8'h00, 32'h0);
    wr(8'h04, {16'h0, n});
    wr(8'h08, {16'h0, p});
    wr(8'h0C, 32'hF);
    wr(8'h00, {24'h0, c});
  endtask

  // edge detection needs two cycles, seven with the filter on; eight covers both
  task automatic pin(input logic v);
    capture_pin <= v;
    repeat (8) @(posedge aclk);
  endtask

  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // hang guard, far above the expected few thousand cycles
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    wrap_up;
  end

  initial begin
    {aresetn, awvalid, wvalid, arvalid, capture_pin} = 5'h0;
    {bready, rready} = 2'h3;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hF;
    irq_ack = 4'h0;
    miscompares = 0;
    checked = 0;
    rows = '{'{8'h00, 32'hF8, 32'hF8, 2'h0}, '{8'h04, 32'hFFFF_1234, 32'h1234, 2'h0},
      '{8'h08, 32'hA55A, 32'hA55A, 2'h0}, '{8'h10, 32'hFF, 32'hF, 2'h0},
      '{8'h0C, 32'h0, 32'h0, 2'h0}, '{8'h14, 32'h1, 32'h0, `TCC_RESP_SLVERR},
      '{8'h00, 32'h0, 32'h0, 2'h0}};
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    // every register starts at zero
    for (i = 0; i < 5; i++) begin
      rd(8'(i * 4));
      chk(rdv, 32'h0);
    end
    // write then read back, timer stopped, upper bytes ignored
    foreach (rows[j]) begin
      wr(rows[j].a, rows[j].d);
      chk({30'h0, rsp}, {30'h0, rows[j].r});
      rd(rows[j].a);
      chk(rdv, rows[j].e);
      chk({30'h0, rsp}, {30'h0, rows[j].r});
    end
    // 8-bit wrap: overflow kept until service
    setup(8'h01, 16'h00FD, 16'h4040);
    wait_req(4'h1);
    chk({28'h0, seen}, 32'h1);
    wr(8'h00, 32'h0);
    rd(8'h04);
    chk(rdv & 32'hFFFF_FF80, 32'h0);
    wr(8'h0C, 32'h0);
    rd(8'h0C);
    chk(rdv, 32'h1);
    irq_ack <= 4'h1;
    @(posedge aclk);
    irq_ack <= 4'h0;
    rd(8'h0C);
    chk(rdv, 32'h0);
    // 16-bit carry into the high byte, then wrap
    setup(8'h81, 16'h00F8, 16'h4040);
    repeat (20) @(posedge aclk);
    wr(8'h00, 32'h0);
    rd(8'h04);
    chk(rdv & 32'hFFFF_FF80, 32'h100);
    setup(8'h81, 16'hFFF8, 16'h4040);
    wait_req(4'h1);
    wr(8'h00, 32'h0);
    rd(8'h04);
    chk(rdv & 32'hFFFF_FF80, 32'h0);
    // unit a fires before unit b
    setup(8'h01, 16'h0010, 16'h1412);
    wait_req(4'h6);
    chk({28'h0, seen}, 32'h2);
    wait_req(4'h4);
    chk({28'h0, seen}, 32'h6);
    // 16-bit: low byte passes compare b, only a may fire
    setup(8'h81, 16'h00F0, 16'h0105);
    wait_req(4'h6);
    chk({28'h0, seen}, 32'h2);
    // count written equal to compare a
    setup(8'h01, 16'h0030, 16'h0030);
    repeat (10) @(posedge aclk);
    wr(8'h00, 32'h0);
    rd(8'h0C);
    chk(rdv, 32'h0);
    // clear on match, period set by compare a
    setup(8'h09, 16'h0000, 16'h0008);
    wait_req(4'h2);
    chk({28'h0, seen} & 32'h3, 32'h2);
    for (i = 0; i < 4; i++) begin
      rd(8'h04);
      chk({31'h0, rdv > 32'h8}, 32'h0);
    end
    // compare a below the count: rollover comes first
    setup(8'h09, 16'h0020, 16'h0008);
    wait_req(4'h3);
    chk({28'h0, seen} & 32'h3, 32'h1);
    // capture with the timer stopped keeps values exact
    setup(8'h50, 16'h0042, 16'h0000);
    pin(1'b1);
    rd(8'h08);
    chk(rdv, 32'h42);
    rd(8'h0C);
    chk(rdv, 32'h8);
    wr(8'h04, 32'h43);
    wr(8'h0C, 32'hF);
    pin(1'b0);
    rd(8'h0C);
    chk(rdv, 32'h0);
    pin(1'b1);
    wr(8'h04, 32'h44);
    pin(1'b0);
    pin(1'b1);
    rd(8'h08);
    chk(rdv, 32'h44);
    wr(8'h00, 32'h40);
    wr(8'h0C, 32'hF);
    wr(8'h04, 32'h55);
    pin(1'b0);
    rd(8'h08);
    chk(rdv, 32'h55);
    wr(8'h00, 32'hD0);
    wr(8'h04, 32'h1234);
    pin(1'b1);
    rd(8'h08);
    chk(rdv, 32'h1234);
    // filter on: a two-cycle pulse is ignored, a steady level is taken
    wr(8'h00, 32'h70);
    wr(8'h04, 32'h66);
    pin(1'b0);
    capture_pin <= 1'b1;
    repeat (2) @(posedge aclk);
    capture_pin <= 1'b0;
    repeat (8) @(posedge aclk);
    rd(8'h08);
    chk(rdv, 32'h1234);
    pin(1'b1);
    rd(8'h08);
    chk(rdv, 32'h1266);
    // divided rates: a span of ten periods gives ten or eleven ticks
    for (i = 0; i < 3; i++) begin
      setup(8'(i + 2), 16'h0000, 16'h4040);
      repeat ((i == 0) ? 80 : (i == 1) ? 640 : 2560) @(posedge aclk);
      wr(8'h00, 32'h0);
      rd(8'h04);
      chk({31'h0, rdv == 32'hA || rdv == 32'hB}, 32'h1);
    end
    wrap_up;
  end
endmodule
